// ---- rtl/pei_defs.vh ----
`ifndef PEI_DEFS_VH
`define PEI_DEFS_VH

// power-mode indication, one-hot
`define PEI_MODE_W 5
`define PEI_MODE_RUN 5'h01
`define PEI_MODE_SLEEP 5'h02
`define PEI_MODE_LPRUN 5'h04
`define PEI_MODE_LPSLEEP 5'h08
`define PEI_MODE_STOP 5'h10

// per-route mode masks, bit order {stop, lpsleep, lprun, sleep, run}
`define PEI_MASK_ALL 5'h1F
`define PEI_MASK_NO_STOP 5'h0F
`define PEI_MASK_RUN_SLEEP 5'h03

// oscillator request owners
`define PEI_REQ_UART 0
`define PEI_REQ_LOWPOWER_UART 1
`define PEI_REQ_I2C 2
`define PEI_REQ_N 3

`endif

// ---- rtl/pei_interconnect.v ----
// Behaviour
// RL1: each route works only in the power modes allowed for its source and destination.
// RL2: timer-to-timer triggers work in run, sleep and low-power modes, not stop.
// RL3: rtc auto-wakeup to general_timer_b works in all modes except stop.
// RL4: rtc event to lowpower_timer works in every mode including stop.
// RL5: oscillator clocks as timer input channels work in every mode except stop.
// RL6: usb start-of-frame to clock_recovery_unit works only in run and sleep.
// RL7: in stop a waking peripheral may request fast_internal_osc, clocking only it.
// RL8: fast_internal_osc switches off by itself when no requester needs it.
// RL9: uart receivers in stop raise a wakeup on a detected start bit.
// RL10: lowpower_uart frame wakeup runs on slow_crystal_clk; uart requests fast osc.
// RL11: i2c address match in stop wakes up and requests fast osc while receiving.
// RL12: a route disallowed in the current mode drives its destination inactive.
// RL13: oscillator requests are or-combined; enable holds until all are withdrawn.
`timescale 1ns/1ps
`default_nettype none
`include "pei_defs.vh"
module pei_interconnect #(
  parameter NTIM = 4,
  parameter NCLK = 4,
  parameter NGPIO = 2
) (
  input wire sys_clk, // system clock, 50 MHz
  input wire rst_n, // synchronous reset, active low
  input wire [4:0] powerMode, // one-hot power mode indication
  input wire [1:0] compOut, // analog_comparator outputs
  input wire [NTIM-1:0] timTrgOut, // any_timer trigger outputs
  input wire rtcWakeup, // rtc auto-wakeup event
  input wire rtcEvent, // rtc alarm/tamper event
  input wire [NCLK-1:0] oscClkIn, // oscillator clock sources
  input wire usbSof, // usb start of frame
  input wire [NGPIO-1:0] gpioIn, // gpio pins
  input wire uartRxd, // uart receive line
  input wire lpuartRxd, // lowpower_uart receive line
  input wire uartBusy, // uart reception in progress
  input wire lpuartFrameDone, // lowpower_uart frame or address match
  input wire i2cAddrMatch, // i2c address match
  input wire i2cBusy, // i2c reception in progress
  output wire [1:0] compToTim, // comparator to general timers
  output wire [1:0] compToLptim, // comparator to lowpower_timer
  output wire [NTIM-1:0] timTrgIn, // any_timer trigger inputs
  output wire rtcToTimerB, // general_timer_b trigger
  output wire rtcToLptim, // lowpower_timer trigger
  output wire [NCLK-1:0] oscToTimCh, // timer measurement channels
  output wire sofToCrs, // clock_recovery_unit sync
  output wire sofToTimerD, // general_timer_d calibration channel
  output wire [NGPIO-1:0] gpioToTim, // gpio to timers
  output wire [NGPIO-1:0] gpioToLptim, // gpio to lowpower_timer
  output wire [NGPIO-1:0] gpioToConv, // gpio to adc/dac triggers
  output reg fastOscEn_r, // fast_internal_osc enable
  output reg [`PEI_REQ_N-1:0] fastOscGate_r, // per-requester clock gates
  output reg uartWake_r, // uart wakeup interrupt
  output reg lpuartWake_r, // lowpower_uart wakeup interrupt
  output reg lpuartLseSel_r, // lowpower_uart on slow_crystal_clk
  output reg i2cWake_r // i2c wakeup interrupt
);
  // pin-level inputs pass two flops
  reg [NGPIO+1:0] pinMeta_r;
  reg [NGPIO+1:0] pinSync_r;
  reg uartRxdPrev_r;
  reg lpuartRxdPrev_r;
  wire [NGPIO-1:0] gpioS;
  wire stopMode;
  wire [`PEI_REQ_N-1:0] oscReq;

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pinMeta_r <= {(NGPIO+2){1'b1}};
      pinSync_r <= {(NGPIO+2){1'b1}};
    end
    else
    begin
      pinMeta_r <= {uartRxd, lpuartRxd, gpioIn};
      pinSync_r <= pinMeta_r;
    end
  end
  assign gpioS = pinSync_r[NGPIO-1:0];
  assign stopMode = |(powerMode & `PEI_MODE_STOP);

  // comparator to general timers, off in stop
  pei_route_gate #(
    .WIDTH(2),
    .MASK(`PEI_MASK_NO_STOP)
  ) uCompTim (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .modeOh(powerMode),
    .srcIn(compOut),
    .dstOut_r(compToTim) // RL1
  );

  // comparator to lowpower_timer, live in every mode
  pei_route_gate #(
    .WIDTH(2),
    .MASK(`PEI_MASK_ALL)
  ) uCompLp (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .modeOh(powerMode),
    .srcIn(compOut),
    .dstOut_r(compToLptim) // RL1
  );

  // timer to timer triggers
  pei_route_gate #(
    .WIDTH(NTIM),
    .MASK(`PEI_MASK_NO_STOP)
  ) uTimTim (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .modeOh(powerMode),
    .srcIn(timTrgOut),
    .dstOut_r(timTrgIn) // RL2
  );

  // rtc auto-wakeup to general_timer_b
  pei_route_gate #(
    .WIDTH(1),
    .MASK(`PEI_MASK_NO_STOP)
  ) uRtcTb (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .modeOh(powerMode),
    .srcIn(rtcWakeup),
    .dstOut_r(rtcToTimerB) // RL3
  );

  // rtc event to lowpower_timer keeps working in stop
  pei_route_gate #(
    .WIDTH(1),
    .MASK(`PEI_MASK_ALL)
  ) uRtcLp (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .modeOh(powerMode),
    .srcIn(rtcEvent),
    .dstOut_r(rtcToLptim) // RL4
  );

  // oscillator clocks as measurement channels
  pei_route_gate #(
    .WIDTH(NCLK),
    .MASK(`PEI_MASK_NO_STOP)
  ) uOscTim (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .modeOh(powerMode),
    .srcIn(oscClkIn),
    .dstOut_r(oscToTimCh) // RL5
  );

  // start of frame to clock_recovery_unit
  pei_route_gate #(
    .WIDTH(1),
    .MASK(`PEI_MASK_RUN_SLEEP)
  ) uSofCrs (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .modeOh(powerMode),
    .srcIn(usbSof),
    .dstOut_r(sofToCrs) // RL6
  );

  // start of frame to general_timer_d calibration channel
  pei_route_gate #(
    .WIDTH(1),
    .MASK(`PEI_MASK_RUN_SLEEP)
  ) uSofTd (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .modeOh(powerMode),
    .srcIn(usbSof),
    .dstOut_r(sofToTimerD) // RL1
  );

  // synchronised gpio to timers
  pei_route_gate #(
    .WIDTH(NGPIO),
    .MASK(`PEI_MASK_NO_STOP)
  ) uGpTim (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .modeOh(powerMode),
    .srcIn(gpioS),
    .dstOut_r(gpioToTim) // RL1
  );

  // synchronised gpio to lowpower_timer, live in stop
  pei_route_gate #(
    .WIDTH(NGPIO),
    .MASK(`PEI_MASK_ALL)
  ) uGpLp (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .modeOh(powerMode),
    .srcIn(gpioS),
    .dstOut_r(gpioToLptim) // RL1
  );

  // synchronised gpio to converter triggers
  pei_route_gate #(
    .WIDTH(NGPIO),
    .MASK(`PEI_MASK_NO_STOP)
  ) uGpCv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .modeOh(powerMode),
    .srcIn(gpioS),
    .dstOut_r(gpioToConv) // RL1
  );

  // uart needs fast osc while receiving; lowpower_uart runs on slow crystal instead
  assign oscReq[`PEI_REQ_UART] = stopMode & uartBusy; // RL10
  assign oscReq[`PEI_REQ_LOWPOWER_UART] = 1'b0;
  assign oscReq[`PEI_REQ_I2C] = stopMode & i2cBusy; // RL11

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      uartRxdPrev_r <= 1'b1;
      lpuartRxdPrev_r <= 1'b1;
      uartWake_r <= 1'b0;
      lpuartWake_r <= 1'b0;
      lpuartLseSel_r <= 1'b0;
      i2cWake_r <= 1'b0;
      fastOscEn_r <= 1'b0;
      fastOscGate_r <= {`PEI_REQ_N{1'b0}};
    end
    else
    begin
      uartRxdPrev_r <= pinSync_r[NGPIO+1];
      lpuartRxdPrev_r <= pinSync_r[NGPIO];
      // falling edge on rx is a start bit
      uartWake_r <= stopMode & uartRxdPrev_r & ~pinSync_r[NGPIO+1]; // RL9
      lpuartWake_r <= stopMode & ((lpuartRxdPrev_r & ~pinSync_r[NGPIO])
        | lpuartFrameDone); // RL9 RL10
      lpuartLseSel_r <= stopMode; // RL10
      i2cWake_r <= stopMode & i2cAddrMatch; // RL11
      fastOscEn_r <= |oscReq; // RL7 RL8 RL13
      fastOscGate_r <= oscReq; // RL7
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pei_route_gate.v ----
`timescale 1ns/1ps
`default_nettype none
module pei_route_gate #(
  parameter WIDTH = 1,
  parameter [4:0] MASK = 5'h1F
) (
  input wire sys_clk, // system clock
  input wire rst_n, // synchronous reset, active low
  input wire [4:0] modeOh, // one-hot power mode
  input wire [WIDTH-1:0] srcIn, // source signals
  output reg [WIDTH-1:0] dstOut_r // gated destination signals
);
  wire allowed;
  assign allowed = |(modeOh & MASK);
  always @(posedge sys_clk)
  begin
    if (!rst_n)
      dstOut_r <= {WIDTH{1'b0}};
    else
      dstOut_r <= allowed ? srcIn : {WIDTH{1'b0}}; // RL12 RL1
  end
endmodule
`default_nettype wire

// ---- testbench/pei_interconnect_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module pei_interconnect_bench;
  logic sys_clk = 1'b0, rst_n = 1'b0, go = 1'b0, rtcWakeup = 1'b0, rtcEvent = 1'b0, usbSof = 1'b0;
  logic [4:0] powerMode = 5'h00;
  logic [3:0] timTrgOut = 4'h0, oscClkIn = 4'h0;
  logic [1:0] compOut = 2'h0, gpioIn = 2'h0;
  logic uartRxd = 1'b1, lpuartRxd = 1'b1, lpuartFrameDone = 1'b0;
  wire [1:0] gpioToTim, gpioToLptim, gpioToConv;
  wire uartWake_r, lpuartWake_r;
  logic [21:0] e, g;
  wire [1:0] compToTim, compToLptim;
  wire [3:0] timTrgIn, oscToTimCh;
  wire [2:0] fastOscGate_r;
  wire rtcToTimerB, rtcToLptim, sofToCrs, sofToTimerD, fastOscEn_r, lpuartLseSel_r, i2cWake_r;
  wire uartBusy, i2cBusy, i2cAddrMatch;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  pei_interconnect dut_u (.*);
  pei_req_model req_u (.*);
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (++cyc > 600) wrap_up(1);
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic t_wake();
    powerMode = 5'h10;
    {uartRxd, lpuartRxd, gpioIn} = 4'h3;
    repeat (3) @(negedge sys_clk);
    chk({uartWake_r, lpuartWake_r, gpioToLptim, gpioToTim, gpioToConv}, 22'h0000F0);
    @(negedge sys_clk);
    chk({uartWake_r, lpuartWake_r, gpioToLptim, gpioToTim, gpioToConv}, 22'h000030);
    lpuartFrameDone = 1'b1;
    @(negedge sys_clk);
    lpuartFrameDone = 1'b0;
    chk({uartWake_r, lpuartWake_r, gpioToLptim, gpioToTim, gpioToConv}, 22'h000070);
    powerMode = 5'h01;
    {uartRxd, lpuartRxd} = 2'h3;
    repeat (3) @(negedge sys_clk);
    {uartRxd, lpuartRxd} = 2'h0;
    repeat (3) @(negedge sys_clk);
    chk({uartWake_r, lpuartWake_r, gpioToLptim, gpioToTim, gpioToConv}, 22'h00003F);
    $display("wake done");
  endtask
  task automatic t_sweep();
    for (int i = 0; i < 12; i++)
    begin
      powerMode = 5'h01 << (i % 6);
      {timTrgOut, rtcWakeup, oscClkIn, compOut, usbSof, rtcEvent} = {13{i < 6}};
      for (int j = 0; j < 8; j++)
      begin
        go = j == 0;
        e[21:6] = i < 6 ? {{11{i % 6 < 4}}, {2{i % 6 < 2}}, {3{i % 6 < 5}}} : 16'h0000;
        e[5:0] = {6{powerMode[4]}} & {uartBusy | i2cBusy, i2cBusy, 1'b0, uartBusy, i2cAddrMatch, 1'b1};
        @(negedge sys_clk);
        g = {timTrgIn, rtcToTimerB, oscToTimCh, compToTim, sofToCrs, sofToTimerD, rtcToLptim,
          compToLptim, fastOscEn_r, fastOscGate_r, i2cWake_r, lpuartLseSel_r};
        chk(g, e);
      end
    end
    $display("sweep done");
  endtask
  initial
  begin
    repeat (6) @(negedge sys_clk);
    rst_n = 1'b1;
    t_sweep();
    t_wake();
    wrap_up(0);
  end
  task automatic wrap_up(input int to);
    fail_count += to;
    $display("cmp %0d fail %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
endmodule
`default_nettype wire

// ---- testbench/pei_interconnect_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module pei_interconnect_props #(parameter NTIM = 4) (
  input wire logic sys_clk, rst_n, usbSof, uartBusy, i2cBusy, i2cAddrMatch, // inputs
  input wire logic sofToCrs, fastOscEn_r, i2cWake_r, // outputs
  input wire logic [NTIM-1:0] timTrgOut, timTrgIn, // triggers
  input wire logic [4:0] powerMode, input wire logic [2:0] fastOscGate_r); // mode, gates
  wire ns = |powerMode[3:0], rs = |powerMode[1:0], st = powerMode[4], rq = uartBusy | i2cBusy;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_TIM: assert property (##1 timTrgIn == $past(timTrgOut & {NTIM{ns}})) else $error("tim");
  AST_SOF: assert property (##1 sofToCrs == $past(usbSof & rs)) else $error("sof");
  AST_OFF: assert property (!rs |=> !sofToCrs) else $error("off");
  AST_REQ: assert property (st && rq |=> fastOscEn_r) else $error("req");
  AST_DROP: assert property (!(st && rq) |=> !fastOscEn_r) else $error("drop");
  AST_GATE: assert property (st && !uartBusy |=> !fastOscGate_r[0]) else $error("gate");
  AST_WAKE: assert property (st && i2cAddrMatch |=> i2cWake_r) else $error("wake");
  AST_NOWK: assert property (!st |=> !i2cWake_r && fastOscGate_r == 3'h0) else $error("nowk");
  cover property (fastOscEn_r ##1 !fastOscEn_r);
  cover property (sofToCrs);
  cover property (i2cWake_r);
endmodule
bind pei_interconnect pei_interconnect_props #(.NTIM(NTIM)) chk_u (.*);
`default_nettype wire

// ---- testbench/pei_req_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pei_req_model (
  input wire logic sys_clk, go, // clock, burst start
  output logic uartBusy, i2cBusy, i2cAddrMatch); // requests
  logic [2:0] cnt_r = 3'h0;
  always @(posedge sys_clk) cnt_r <= go ? 3'h1 : cnt_r + {2'h0, |cnt_r};
  assign {uartBusy, i2cBusy, i2cAddrMatch} = {cnt_r > 3'h2, cnt_r[2:1] == 2'h1, cnt_r == 3'h1};
endmodule
`default_nettype wire
